//--- hdl/dmscp_dev.sv
// Device end: strap capture, two-wire slave and four-wire shift-register slave
`timescale 1ns/1ns
module dmscp_dev (
  // Link
  dmscp_link_if.dev        link,
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Power-up straps, 4-level pins coded as 2 bits
  input  wire logic [1:0]  mode_level,
  input  wire logic [1:0]  address_strap_a,
  input  wire logic [1:0]  address_strap_b,
  // Register port toward the register file
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  output logic             reg_wr,
  input  wire logic [7:0]  reg_rdata,
  // Selected mode
  output logic             twi_mode,
  output logic             spi_mode,
  output logic             power_save
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers and one-time capture after reset release
  logic [5:0] strap_s1_ff, strap_s2_ff;
  logic [1:0] strap_wait_ff;
  logic       strap_done_ff;
  logic [6:0] own_addr_ff;

  always_ff @(posedge mclk) begin
    strap_s1_ff <= {mode_level, address_strap_a, address_strap_b};
    strap_s2_ff <= strap_s1_ff;
  end

  // Straps are caught once; later changes on the pins are ignored
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strap_wait_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      twi_mode      <= 1'b0;
      spi_mode      <= 1'b0;
      power_save    <= 1'b0;
      own_addr_ff   <= 7'h00;
    end else if (!strap_done_ff) begin
      strap_wait_ff <= strap_wait_ff + 2'h1;
      if (strap_wait_ff == dmscp_pkg::STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        twi_mode      <= (strap_s2_ff[5:4] == dmscp_pkg::LVL_L);
        spi_mode      <= (strap_s2_ff[5:4] == dmscp_pkg::LVL_F) |
                         (strap_s2_ff[5:4] == dmscp_pkg::LVL_H);
        power_save    <= (strap_s2_ff[5:4] == dmscp_pkg::LVL_H);
        own_addr_ff   <= dmscp_pkg::SMB_ADDR_LO + 7'(strap_s2_ff[3:0]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire line sampling; edges are seen on the mclk grid
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;

  always_ff @(posedge mclk) begin
    scl_s1_ff <= link.scl;
    scl_s2_ff <= scl_s1_ff;
    scl_d_ff  <= scl_s2_ff;
    sda_s1_ff <= link.sda;
    sda_s2_ff <= sda_s1_ff;
    sda_d_ff  <= sda_s2_ff;
  end

  wire twi_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  wire twi_stop  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  wire scl_rise  = scl_s2_ff & ~scl_d_ff;
  wire scl_fall  = ~scl_s2_ff & scl_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave state machine
  dmscp_pkg::dmscp_twi_state_type twi_st_ff, twi_ret_ff;
  logic [3:0] twi_cnt_ff;
  logic [7:0] twi_sh_ff;
  logic [7:0] twi_tx_ff;
  logic       twi_drive_ff;

  wire byte_end  = scl_fall & (twi_cnt_ff == 4'h8);
  wire addr_hit  = (twi_sh_ff[7:1] == own_addr_ff);
  wire reg_done  = (twi_st_ff == dmscp_pkg::T_REG) & byte_end;
  wire data_done = (twi_st_ff == dmscp_pkg::T_DATA) & byte_end;

  always_ff @(posedge mclk) begin
    if (!rst_b || !twi_mode) begin
      twi_st_ff    <= dmscp_pkg::T_IDLE;
      twi_ret_ff   <= dmscp_pkg::T_IDLE;
      twi_cnt_ff   <= 4'h0;
      twi_sh_ff    <= 8'h00;
      twi_tx_ff    <= 8'h00;
      twi_drive_ff <= 1'b0;
    end else if (twi_start) begin
      // Also covers the repeated start of a read
      twi_st_ff    <= dmscp_pkg::T_ADDR;
      twi_cnt_ff   <= 4'h0;
      twi_drive_ff <= 1'b0;
    end else if (twi_stop) begin
      twi_st_ff    <= dmscp_pkg::T_IDLE;
      twi_drive_ff <= 1'b0;
    end else begin
      case (twi_st_ff)
        dmscp_pkg::T_ADDR, dmscp_pkg::T_REG, dmscp_pkg::T_DATA: begin
          if (scl_rise) begin
            twi_sh_ff  <= {twi_sh_ff[6:0], sda_s2_ff};
            twi_cnt_ff <= twi_cnt_ff + 4'h1;
          end else if (byte_end) begin
            twi_cnt_ff <= 4'h0;
            if (twi_st_ff == dmscp_pkg::T_ADDR && !addr_hit) begin
              twi_st_ff <= dmscp_pkg::T_SKIP;
            end else begin
              twi_drive_ff <= 1'b1;
              twi_st_ff    <= dmscp_pkg::T_ACK;
              if (twi_st_ff == dmscp_pkg::T_ADDR)
                twi_ret_ff <= twi_sh_ff[0] ? dmscp_pkg::T_READ : dmscp_pkg::T_REG;
              else if (twi_st_ff == dmscp_pkg::T_REG)
                twi_ret_ff <= dmscp_pkg::T_DATA;
              else
                twi_ret_ff <= dmscp_pkg::T_SKIP;
            end
          end
        end
        dmscp_pkg::T_ACK: if (scl_fall) begin
          // Ack slot over; the first read bit goes out on the same edge
          twi_st_ff    <= twi_ret_ff;
          twi_tx_ff    <= reg_rdata;
          twi_drive_ff <= (twi_ret_ff == dmscp_pkg::T_READ) & ~reg_rdata[7];
        end
        dmscp_pkg::T_READ: begin
          if (scl_rise) begin
            twi_cnt_ff <= twi_cnt_ff + 4'h1;
          end else if (byte_end) begin
            // Release for the host answer; one byte per read
            twi_drive_ff <= 1'b0;
            twi_st_ff    <= dmscp_pkg::T_SKIP;
          end else if (scl_fall) begin
            twi_tx_ff    <= {twi_tx_ff[6:0], 1'b0};
            twi_drive_ff <= ~twi_tx_ff[6];
          end
        end
        default: twi_drive_ff <= 1'b0;
      endcase
    end
  end

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = twi_drive_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Four-wire shift register on the link clock
  logic [16:0] spi_sr_ff;
  logic [4:0]  spi_cnt_ff;
  logic        spi_started_ff;
  logic [16:0] spi_rsp_ff;

  // Cleared by the frame's own select, so no edge after the frame is needed
  always_ff @(posedge link.sck or posedge link.ss_n) begin
    if (link.ss_n) spi_started_ff <= 1'b0;
    else           spi_started_ff <= 1'b1;
  end

  // Input is only taken inside a frame; count wraps every 17 bits for chains
  always_ff @(posedge link.sck) begin
    if (!link.ss_n) begin
      spi_sr_ff  <= spi_started_ff ? {spi_sr_ff[15:0], link.mosi} :
                                     {spi_rsp_ff[15:0], link.mosi};
      spi_cnt_ff <= (!spi_started_ff) ? 5'h01 :
                    (spi_cnt_ff == 5'(dmscp_pkg::FRAME_BITS - 1)) ? 5'h00 :
                    spi_cnt_ff + 5'h01;
    end
  end

  // Before the first edge the loaded answer shows its top bit
  assign link.miso_o  = spi_started_ff ? spi_sr_ff[16] : spi_rsp_ff[16];
  assign link.miso_oe = spi_mode & ~link.ss_n;

  ////////////////////////////////////////////////////////////////////////////
  // Frame end handling on mclk; shift register is stable while select is high
  logic        ss_s1_ff, ss_s2_ff, ss_d_ff;
  logic [16:0] spi_cap_ff;
  logic        spi_issue_ff, spi_load_ff;

  always_ff @(posedge mclk) begin
    ss_s1_ff <= link.ss_n;
    ss_s2_ff <= ss_s1_ff;
    ss_d_ff  <= ss_s2_ff;
  end

  wire spi_end = spi_mode & ss_s2_ff & ~ss_d_ff;
  wire spi_ok  = (spi_cnt_ff == 5'h00);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      spi_cap_ff   <= 17'h00000;
      spi_issue_ff <= 1'b0;
      spi_load_ff  <= 1'b0;
      spi_rsp_ff   <= 17'h00000;
    end else begin
      spi_issue_ff <= spi_end & spi_ok;
      spi_load_ff  <= spi_issue_ff;
      if (spi_end) spi_cap_ff <= spi_sr_ff;
      // Read answer carries command, address and fresh data; a write echoes itself
      if (spi_load_ff)
        spi_rsp_ff <= (spi_cap_ff[dmscp_pkg::RW_BIT] == dmscp_pkg::DIR_RD) ?
                      {dmscp_pkg::DIR_RD, spi_cap_ff[15:8], reg_rdata} :
                      spi_cap_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port, shared by both modes; only one mode is ever live
  wire spi_wr = spi_issue_ff & (spi_cap_ff[dmscp_pkg::RW_BIT] == dmscp_pkg::DIR_WR);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_addr  <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr    <= 1'b0;
    end else begin
      reg_wr <= data_done | spi_wr;
      if (reg_done)          reg_addr  <= twi_sh_ff;
      else if (spi_issue_ff) reg_addr  <= spi_cap_ff[15:8];
      if (data_done)         reg_wdata <= twi_sh_ff;
      else if (spi_issue_ff) reg_wdata <= spi_cap_ff[7:0];
    end
  end

endmodule : dmscp_dev

//--- hdl/dmscp_host.sv
// Host end: two-wire master and four-wire master behind one command port
`timescale 1ns/1ns
module dmscp_host (
  // Link
  dmscp_link_if.host       link,
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_spi,
  input  wire logic        cmd_read,
  input  wire logic [6:0]  cmd_dev,
  input  wire logic [7:0]  cmd_reg,
  input  wire logic [7:0]  cmd_wdata,
  // Answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_nack
);
  dmscp_pkg::dmscp_host_state_type st_ff;
  logic [7:0]  tcnt_ff;
  logic [1:0]  ph_ff;
  logic [4:0]  bitn_ff;
  logic [2:0]  step_ff;
  logic        frame_ff;
  logic [8:0]  rx_ff;
  logic        spi_ff, rd_ff;
  logic [6:0]  dev_ff;
  logic [7:0]  reg_ff, wd_ff;
  logic        sda_s1_ff, sda_s2_ff, miso_s1_ff, miso_s2_ff;
  logic        scl_rel_ff, sda_rel_ff, sck_ff, ss_n_ff, mosi_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Step decode: write is S,A,R,D,P and read is S,A,R,S,A,D,P
  wire [7:0]  div       = spi_ff ? 8'(dmscp_pkg::SPI_TICK_CYC) : 8'(dmscp_pkg::SMB_TICK_CYC);
  wire        tick      = (tcnt_ff == div - 8'h01);
  wire [2:0]  last_step = rd_ff ? 3'h6 : 3'h4;
  wire        is_start  = (step_ff == 3'h0) | (rd_ff & step_ff == 3'h3);
  wire        is_stop   = (step_ff == last_step);
  wire        is_byte   = ~is_start & ~is_stop;
  wire        rd_byte   = rd_ff & (step_ff == 3'h5);
  wire [7:0]  byte_val  = (step_ff == 3'h1) ? {dev_ff, dmscp_pkg::DIR_WR} :
                          (step_ff == 3'h2) ? reg_ff :
                          !rd_ff            ? wd_ff :
                          (step_ff == 3'h4) ? {dev_ff, dmscp_pkg::DIR_RD} : 8'hff;
  wire [8:0]  bit_word  = {byte_val, 1'b1} << bitn_ff;  // Ninth bit released for ack
  wire        sym_done  = ~is_byte | (bitn_ff == 5'h08);
  wire        scl_high  = (ph_ff == 2'h1) | (ph_ff == 2'h2);
  wire [16:0] spi_word  = frame_ff ? {dmscp_pkg::DIR_RD, dmscp_pkg::DUMMY_ADDR,
                                      dmscp_pkg::FILL_BYTE} :
                          {rd_ff, reg_ff, rd_ff ? dmscp_pkg::FILL_BYTE : wd_ff};
  wire [16:0] spi_shift = spi_word << bitn_ff;
  wire        in_twi    = (st_ff == dmscp_pkg::H_TWI);
  wire        in_spi    = (st_ff == dmscp_pkg::H_SPI);

  // Pin levels per phase: start falls sda under high scl, stop raises it
  wire nxt_scl  = ~in_twi | (is_stop ? (ph_ff != 2'h0) : scl_high);
  wire nxt_sda  = ~in_twi | (is_start ? (ph_ff < 2'h2) :
                             is_stop ? (ph_ff >= 2'h2) : bit_word[8]);
  wire nxt_ss_n = ~in_spi;
  wire nxt_sck  = in_spi & ph_ff[0];

  assign cmd_ready     = (st_ff == dmscp_pkg::H_IDLE);
  assign link.scl_m_o  = 1'b0;
  assign link.scl_m_oe = ~scl_rel_ff;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~sda_rel_ff;
  assign link.sck      = sck_ff;
  assign link.ss_n     = ss_n_ff;
  assign link.mosi     = mosi_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers and input synchronisers
  always_ff @(posedge mclk) begin
    sda_s1_ff  <= link.sda;
    sda_s2_ff  <= sda_s1_ff;
    miso_s1_ff <= link.miso;
    miso_s2_ff <= miso_s1_ff;
    scl_rel_ff <= ~rst_b | nxt_scl;
    sda_rel_ff <= ~rst_b | nxt_sda;
    sck_ff     <= rst_b & nxt_sck;
    ss_n_ff    <= ~rst_b | nxt_ss_n;
    mosi_ff    <= rst_b & spi_shift[16];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_ff <= dmscp_pkg::H_IDLE;
      tcnt_ff <= 8'h00; ph_ff <= 2'h0; bitn_ff <= 5'h00; step_ff <= 3'h0;
      frame_ff <= 1'b0; rx_ff <= 9'h000; spi_ff <= 1'b0; rd_ff <= 1'b0;
      dev_ff <= 7'h00; reg_ff <= 8'h00; wd_ff <= 8'h00;
      rsp_valid <= 1'b0; rsp_data <= 8'h00; rsp_nack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      tcnt_ff   <= (cmd_ready | tick) ? 8'h00 : tcnt_ff + 8'h01;
      case (st_ff)
        dmscp_pkg::H_IDLE: if (cmd_valid) begin
          spi_ff <= cmd_spi; rd_ff <= cmd_read; dev_ff <= cmd_dev;
          reg_ff <= cmd_reg; wd_ff <= cmd_wdata; rsp_nack <= 1'b0;
          ph_ff <= 2'h0; bitn_ff <= 5'h00; step_ff <= 3'h0; frame_ff <= 1'b0;
          st_ff <= cmd_spi ? dmscp_pkg::H_SPI : dmscp_pkg::H_TWI;
        end
        dmscp_pkg::H_TWI: if (tick) begin
          ph_ff <= ph_ff + 2'h1;
          // Only byte bits are kept; a stop phase would push the read byte out of place
          if (ph_ff == 2'h2 && is_byte) rx_ff <= {rx_ff[7:0], sda_s2_ff};
          if (ph_ff == 2'h3 && sym_done) begin
            bitn_ff <= 5'h00;
            if (is_stop) st_ff <= dmscp_pkg::H_DONE;
            else if (is_byte && !rd_byte && rx_ff[0]) begin
              rsp_nack <= 1'b1;
              step_ff  <= last_step;
            end else step_ff <= step_ff + 3'h1;
          end else if (ph_ff == 2'h3) bitn_ff <= bitn_ff + 5'h01;
        end
        dmscp_pkg::H_SPI: if (tick) begin
          ph_ff <= {1'b0, ~ph_ff[0]};
          // Sample just before the rising edge, when the device output is settled
          if (!ph_ff[0]) rx_ff <= {rx_ff[7:0], miso_s2_ff};
          else if (bitn_ff == 5'(dmscp_pkg::CHAIN_BITS - 1)) begin
            bitn_ff <= 5'h00;
            st_ff   <= dmscp_pkg::H_GAP;
          end else bitn_ff <= bitn_ff + 5'h01;
        end
        dmscp_pkg::H_GAP: if (tick) begin
          if (bitn_ff == 5'(dmscp_pkg::SPI_GAP_TICKS - 1)) begin
            bitn_ff <= 5'h00;
            ph_ff   <= 2'h0;
            if (rd_ff && !frame_ff) begin
              frame_ff <= 1'b1;
              st_ff    <= dmscp_pkg::H_SPI;
            end else st_ff <= dmscp_pkg::H_DONE;
          end else bitn_ff <= bitn_ff + 5'h01;
        end
        dmscp_pkg::H_DONE: begin
          rsp_valid <= 1'b1;
          rsp_data  <= spi_ff ? rx_ff[7:0] : rx_ff[8:1];
          st_ff     <= dmscp_pkg::H_IDLE;
        end
        default: st_ff <= dmscp_pkg::H_IDLE;
      endcase
    end
  end
endmodule : dmscp_host

//--- hdl/dmscp_link_if.sv
// Link between host and device: two-wire lines and four-wire lines
`timescale 1ns/1ns
interface dmscp_link_if;
  // Two-wire, open-drain: each party only pulls low
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Four-wire; a chain would ripple mosi through each device
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // Wired-and with pull-ups
  assign scl  = ~(scl_m_oe & ~scl_m_o);
  assign sda  = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, sck, ss_n, mosi,
                input  sda, miso);
  modport dev  (output sda_s_o, sda_s_oe, miso_o, miso_oe,
                input  scl, sda, sck, ss_n, mosi);
endinterface : dmscp_link_if

//--- hdl/dmscp_pkg.sv
// Shared constants and types of the dual-mode serial configuration port
//
// What this block does
// - Address byte: seven bits high, write is zero
// - Host clocks; both two-wire lines open-drain
// - Start and stop edges made and detected
// - Nine clocks per byte, ninth is acknowledge
// - Write: start, address, register, data, stop
// - Read: register, restart, address-read, byte, nack
// - Float or high level selects four-wire slave
// - Frames are 17 bits under low select
// - Select high: ignore input, release output
// - Direction, address msb first, data msb first
// - Previous frame shifts out while new shifts in
// - Output driver enabled directly by select low
// - Write executes when select returns high
// - Frame starts rising edge; device samples rising
// - Read is two frames; second reads 0xff
// - First read frame data bits are ones
// - Last frame returns command, address, data
// - Chain of N needs 17 x N clocks
// - Chain shares clock, select; data ripples through
// - Select pin sampled at power-up picks mode
// - Straps give slave address 1d to 2c
package dmscp_pkg;

  // Clocking and link rates
  localparam int MCLK_HZ       = 25_000_000;
  localparam int SMB_SCL_HZ    = 100_000;
  localparam int SPI_SCK_HZ    = 2_000_000;
  localparam int SMB_TICK_CYC  = MCLK_HZ / (4 * SMB_SCL_HZ);
  localparam int SPI_TICK_CYC  = MCLK_HZ / (2 * SPI_SCK_HZ);
  localparam int SPI_GAP_NS    = 400;
  localparam int SPI_GAP_CYC   = (SPI_GAP_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SPI_GAP_TICKS = (SPI_GAP_CYC + SPI_TICK_CYC - 1) / SPI_TICK_CYC;

  // Frame layout
  localparam int         FRAME_BITS = 17;
  localparam int         CHAIN_LEN  = 1;
  localparam int         CHAIN_BITS = FRAME_BITS * CHAIN_LEN;
  localparam int         RW_BIT     = 16;
  localparam logic       DIR_WR     = 1'b0;
  localparam logic       DIR_RD     = 1'b1;
  localparam logic [7:0] DUMMY_ADDR = 8'hff;
  localparam logic [7:0] FILL_BYTE  = 8'hff;

  // Power-up straps; levels coded low, reserved, float, high
  localparam logic [1:0] LVL_L       = 2'h0;
  localparam logic [1:0] LVL_R       = 2'h1;
  localparam logic [1:0] LVL_F       = 2'h2;
  localparam logic [1:0] LVL_H       = 2'h3;
  localparam logic [6:0] SMB_ADDR_LO = 7'h1d;
  localparam logic [1:0] STRAP_WAIT  = 2'h3;

  typedef enum logic [6:0] {
    T_IDLE = 7'h01, T_ADDR = 7'h02, T_REG = 7'h04, T_DATA = 7'h08,
    T_ACK  = 7'h10, T_READ = 7'h20, T_SKIP = 7'h40
  } dmscp_twi_state_type;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01, H_TWI = 5'h02, H_SPI = 5'h04, H_GAP = 5'h08, H_DONE = 5'h10
  } dmscp_host_state_type;

endpackage : dmscp_pkg

//--- tb/dmscp_link_asserts.sv
// Concurrent checks on the link lines between the host end and the device end
`timescale 1ns/1ns
module dmscp_link_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Two-wire lines
  input wire logic scl,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe,
  // Four-wire lines
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_oe
);
  logic       sck_d_ff;
  logic       sck_rise;
  logic [4:0] sck_cnt_ff;
  logic [4:0] nxt_sck_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Rises of the link clock inside a frame; mclk sampling is safe, sck is slow
  assign sck_rise    = sck & ~sck_d_ff;
  assign nxt_sck_cnt = ss_n ? 5'h0 : sck_cnt_ff + {4'h0, sck_rise};
  always_ff @(posedge mclk) begin
    sck_d_ff   <= sck;
    sck_cnt_ff <= rst_b ? nxt_sck_cnt : 5'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One domain only, so clock and disable are given once
  default clocking mclk_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Four-wire select, output enable and framing
  AST_MISO_RELEASED: assert property (ss_n |-> !miso_oe)
    else $error("miso driven while select high");
  AST_MISO_ON_SELECT: assert property ($fell(ss_n) |-> miso_oe)
    else $error("miso not enabled at select fall");
  AST_MISO_CAUSE: assert property ($rose(miso_oe) |-> $fell(ss_n))
    else $error("miso enabled without select fall");
  AST_FRAME_LEN: assert property ($rose(ss_n) |-> sck_cnt_ff == dmscp_pkg::CHAIN_BITS)
    else $error("frame length wrong");
  AST_FRAME_SCK_LOW: assert property ($fell(ss_n) |-> !sck [*3])
    else $error("frame does not open with sck low");
  AST_SELECT_GAP: assert property ($rose(ss_n) |=> ss_n [*7])
    else $error("select gap too short");
  AST_MOSI_HELD: assert property (!ss_n && sck && $past(sck) |-> $stable(mosi))
    else $error("mosi changed while sck high");
  // Two-wire data line: device moves only while scl is low
  AST_SLAVE_SDA_STILL: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device changed sda while scl high");
  AST_NO_FIGHT: assert property (scl |-> !(sda_s_oe && sda_m_oe))
    else $error("both ends pull sda while scl high");
endmodule : dmscp_link_asserts

//--- tb/dual_mode_serial_config_port_bench.sv
// Self-checking bench joining host end and device end over one link
`timescale 1ns/1ns
module dual_mode_serial_config_port_bench;
  localparam logic [1:0] STRAP_A  = 2'h1;
  localparam logic [1:0] STRAP_B  = 2'h2;
  localparam logic [6:0] OWN_ADDR = dmscp_pkg::SMB_ADDR_LO + {3'h0, STRAP_A, STRAP_B};
  localparam logic [2:0] MODE_EXP [4] = '{3'h4, 3'h0, 3'h2, 3'h3};

  logic        mclk;
  logic        rst_b;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_spi;
  logic        cmd_read;
  logic [6:0]  cmd_dev;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_wdata;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_nack;
  logic [1:0]  mode_level;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic [7:0]  reg_rdata;
  logic        twi_mode;
  logic        spi_mode;
  logic        power_save;
  logic [7:0]  regs [256];
  logic [16:0] mosi_sh;
  logic [16:0] miso_sh;
  logic [27:0] twi_sh;
  logic [16:0] mosi_last;
  logic [16:0] mosi_prev;
  int          miscompares;
  int          samples_checked;
  int          wr_count;

  //////////////////////////////////////////////////////////////////////////////
  // Both ends and the checker on one link
  dmscp_link_if dmscp_link_if_i ();
  dmscp_host dmscp_host_i (.link(dmscp_link_if_i), .mclk(mclk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_spi(cmd_spi), .cmd_read(cmd_read),
    .cmd_dev(cmd_dev), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  dmscp_dev dmscp_dev_i (.link(dmscp_link_if_i), .mclk(mclk), .rst_b(rst_b),
    .mode_level(mode_level), .address_strap_a(STRAP_A), .address_strap_b(STRAP_B),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .twi_mode(twi_mode), .spi_mode(spi_mode), .power_save(power_save));
  dmscp_link_asserts dmscp_link_asserts_i (.mclk(mclk), .rst_b(rst_b),
    .scl(dmscp_link_if_i.scl), .sda_m_oe(dmscp_link_if_i.sda_m_oe),
    .sda_s_oe(dmscp_link_if_i.sda_s_oe), .sck(dmscp_link_if_i.sck),
    .ss_n(dmscp_link_if_i.ss_n), .mosi(dmscp_link_if_i.mosi),
    .miso_oe(dmscp_link_if_i.miso_oe));

  // Free-running system clock
  always #20 mclk = ~mclk;

  // Register file behind the device; changes only on the write strobe
  assign reg_rdata = regs[reg_addr];
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      regs[reg_addr] <= reg_wdata;
      wr_count <= wr_count + 1;
    end
  end

  // Wire monitors: last frame each way, and every two-wire bit seen on a scl rise
  always @(posedge dmscp_link_if_i.sck) begin
    if (dmscp_link_if_i.ss_n === 1'b0) begin
      mosi_sh <= {mosi_sh[15:0], dmscp_link_if_i.mosi};
      miso_sh <= {miso_sh[15:0], dmscp_link_if_i.miso};
    end
  end
  always @(posedge dmscp_link_if_i.scl) twi_sh <= {twi_sh[26:0], dmscp_link_if_i.sda};
  // Frames seen at each select rise; a read leaves both of its frames here
  always @(posedge dmscp_link_if_i.ss_n) begin
    mosi_prev <= mosi_last;
    mosi_last <= mosi_sh;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare, verdict, reset and one host command
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic conclude;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Straps must stay put from reset until the device has captured them
  task automatic do_reset(input logic [1:0] lvl);
    @(negedge mclk);
    rst_b = 1'b0;
    mode_level = lvl;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : do_reset

  task automatic run_cmd(input logic spi, input logic rd, input logic [6:0] dev,
                         input logic [7:0] ra, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge mclk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      conclude();
    end
    cmd_spi = spi;
    cmd_read = rd;
    cmd_dev = dev;
    cmd_reg = ra;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      conclude();
    end
  endtask : run_cmd

  //////////////////////////////////////////////////////////////////////////////
  // Each mode level in turn, then that mode's traffic and a two-wire write it must refuse
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_spi = 1'b0;
    cmd_read = 1'b0;
    cmd_dev = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    mode_level = dmscp_pkg::LVL_L;
    miscompares = 0;
    samples_checked = 0;
    wr_count = 0;
    for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'ha5;
    for (int m = 0; m < 4; m++) begin
      do_reset(2'(m));
      check({29'h0, twi_mode, spi_mode, power_save}, {29'h0, MODE_EXP[m]});
      if (m == 0) begin
        run_cmd(1'b0, 1'b0, OWN_ADDR, 8'h5a, 8'hc3);
        check({4'h0, twi_sh}, {4'h0, OWN_ADDR, 2'h0, 8'h5a, 1'b0, 8'hc3, 2'h0});
        check({31'h0, rsp_nack}, 32'h0);
        run_cmd(1'b0, 1'b1, OWN_ADDR, 8'h5a, 8'h00);
        check({24'h0, rsp_data}, 32'hc3);
        check({13'h0, twi_sh[18:0]}, {13'h0, OWN_ADDR, 2'h2, 8'hc3, 2'h2});
        run_cmd(1'b0, 1'b0, OWN_ADDR + 7'h1, 8'h5a, 8'h3c);
        check({31'h0, rsp_nack}, 32'h1);
        check({22'h0, twi_sh[9:0]}, {22'h0, OWN_ADDR + 7'h1, 3'h2});
        check(32'(wr_count), 32'h1);
      end else if (m == 1) begin
        run_cmd(1'b0, 1'b0, OWN_ADDR, 8'h5a, 8'h11);
        check({31'h0, rsp_nack}, 32'h1);
      end else begin
        run_cmd(1'b1, 1'b0, 7'h00, 8'h11, 8'h7e);
        check({15'h0, mosi_sh}, {15'h0, dmscp_pkg::DIR_WR, 16'h117e});
        run_cmd(1'b1, 1'b0, 7'h00, 8'h22, 8'h81);
        check({15'h0, miso_sh}, {15'h0, dmscp_pkg::DIR_WR, 16'h117e});
        check({24'h0, regs[8'h22]}, 32'h81);
        run_cmd(1'b1, 1'b1, 7'h00, 8'h11, 8'h00);
        check({24'h0, rsp_data}, 32'h7e);
        check({15'h0, miso_sh}, {15'h0, dmscp_pkg::DIR_RD, 16'h117e});
        check({15'h0, mosi_prev}, {15'h0, dmscp_pkg::DIR_RD, 8'h11, 8'hff});
        check({15'h0, mosi_sh}, {15'h0, dmscp_pkg::DIR_RD, 16'hffff});
        run_cmd(1'b1, 1'b0, 7'h00, 8'h33, 8'h00);
        check({15'h0, miso_sh}, {15'h0, dmscp_pkg::DIR_RD, 16'hff5a});
        run_cmd(1'b0, 1'b0, OWN_ADDR, 8'h33, 8'h55);
        check({31'h0, rsp_nack}, 32'h1);
      end
    end
    conclude();
  end
endmodule : dual_mode_serial_config_port_bench
